// >>> design/ocd_osc_div.sv
// Oscillator mode control, warm-up, system clock select and 21-stage divider
module ocd_osc_div #(
	parameter bit LOW_IS_RC  = 1'b0,
	parameter bit HIGH_IS_RC = 1'b0
) (
	input  wire logic        clk_i,           // 100 MHz block clock
	input  wire logic        rstn_i,          // Asynchronous reset, active low
	input  wire logic [2:0]  rf_page_i,       // Register file page
	input  wire logic [2:0]  rf_addr_i,       // Register file address
	input  wire logic [3:0]  rf_wdata_i,      // Register write data
	input  wire logic        rf_we_i,         // Register write strobe
	output logic      [3:0]  rf_rdata_o,      // Register read data
	input  wire logic        halt_i,          // HALT instruction executed
	input  wire logic        wake_i,          // Interrupt request pulse
	input  wire logic        low_osc_tick_i,  // Low oscillator pulse
	input  wire logic        high_osc_tick_i, // High oscillator pulse
	output logic             low_osc_en_o,    // Low oscillator run
	output logic             high_osc_en_o,   // High oscillator run
	output logic             low_ready_o,     // Low warm-up done
	output logic             high_ready_o,    // High warm-up done
	output logic             sys_sel_high_o,  // System clock source is high
	output logic             cpu_run_o,       // System clock enabled
	output logic             sys_clk_tick_o,  // System clock pulse
	output logic             resume_o,        // Jump to vector pulse
	output logic             display_clk_o,   // Display clock pulse
	output logic             quad_clk_o,      // Quadrupler clock pulse
	output logic [20:0]      div_o            // Divider stages 1..21
);

	// Keep mask for the divider after a segment clear
	function automatic logic [20:0] ocd_keep_mask(input logic [3:0] clr);
		logic [20:0] m;
		m = '1;
		if (clr[0]) m[ocd_pkg::SEG2_LSB-1:0] = '0;
		if (clr[1]) m[ocd_pkg::SEG3_LSB-1:ocd_pkg::SEG2_LSB] = '0;
		if (clr[2]) m[ocd_pkg::SEG4_LSB-1:ocd_pkg::SEG3_LSB] = '0;
		if (clr[3]) m[ocd_pkg::DIV_STAGES-1:ocd_pkg::SEG4_LSB] = '0;
		return m;
	endfunction : ocd_keep_mask

	logic [1:0]          rst_sync_r;
	logic                rst_n;
	ocd_pkg::ocd_ctrl_t  ctrl_r;
	logic [1:0]          eff_r;
	ocd_pkg::ocd_state_t state_r;
	logic [14:0]         hi_cnt_r;
	logic [8:0]          lo_cnt_r;
	logic                wake_pend_r;
	logic                mode_wr;
	logic                clr_wr;
	logic                sys_en;
	logic                sel_tick;
	logic                stage6_carry;
	logic                upper_adv;
	logic                target_high;
	logic                lo_adv;
	logic [20:0]         div_nxt;

	// Reset release through two flip-flops
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) rst_sync_r <= 2'h0;
		else rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// Register file decode
	assign mode_wr = rf_we_i && rf_page_i == ocd_pkg::PAGE_OSC && rf_addr_i == ocd_pkg::ADDR_MODE;
	assign clr_wr  = rf_we_i && rf_page_i == ocd_pkg::PAGE_OSC && rf_addr_i == ocd_pkg::ADDR_DIVCLR;

	// Software mode bits and applied mode; all-off is held back until HALT
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= '{disp_gate: ocd_pkg::DISP_GATE_RST,
			            high_run: ocd_pkg::MODE_RST[ocd_pkg::BIT_HIGH_RUN],
			            low_run: ocd_pkg::MODE_RST[ocd_pkg::BIT_LOW_RUN]};
			eff_r  <= ocd_pkg::MODE_RST;
		end else if (state_r == ocd_pkg::OCD_STOP && wake_i) begin
			ctrl_r.high_run <= 1'b1;
			ctrl_r.low_run  <= 1'b1;
			eff_r           <= ocd_pkg::BOTH_RUNNING_MODE;
		end else if (mode_wr) begin
			ctrl_r <= rf_wdata_i[2:0];
			if (rf_wdata_i[1:0] != ocd_pkg::ALL_OFF_MODE) eff_r <= rf_wdata_i[1:0];
		end
	end

	// Read port answers the mode register, other addresses read zero
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) rf_rdata_o <= 4'h0;
		else if (rf_page_i == ocd_pkg::PAGE_OSC && rf_addr_i == ocd_pkg::ADDR_MODE)
			rf_rdata_o <= {1'b0, ctrl_r};
		else rf_rdata_o <= 4'h0;
	end

	// Power state: HALT entry by requested mode, interrupt wake
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) state_r <= ocd_pkg::OCD_RUN;
		else begin
			unique case (state_r)
				ocd_pkg::OCD_RUN: begin
					if (halt_i && {ctrl_r.high_run, ctrl_r.low_run} == ocd_pkg::ALL_OFF_MODE)
						state_r <= ocd_pkg::OCD_STOP;
					else if (halt_i && {ctrl_r.high_run, ctrl_r.low_run} == ocd_pkg::LOW_ONLY_MODE)
						state_r <= ocd_pkg::OCD_HALT;
				end
				ocd_pkg::OCD_HALT: if (wake_i) state_r <= ocd_pkg::OCD_RUN;
				ocd_pkg::OCD_STOP: if (wake_i) state_r <= ocd_pkg::OCD_RUN;
				default: state_r <= ocd_pkg::OCD_RUN;
			endcase
		end
	end

	// Oscillator run controls from power state and applied mode
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			low_osc_en_o  <= ocd_pkg::MODE_RST[ocd_pkg::BIT_LOW_RUN];
			high_osc_en_o <= ocd_pkg::MODE_RST[ocd_pkg::BIT_HIGH_RUN];
		end else begin
			low_osc_en_o  <= (state_r == ocd_pkg::OCD_RUN && eff_r[ocd_pkg::BIT_LOW_RUN]) ||
			                 state_r == ocd_pkg::OCD_HALT;
			high_osc_en_o <= state_r == ocd_pkg::OCD_RUN && eff_r[ocd_pkg::BIT_HIGH_RUN];
		end
	end

	// High crystal warm-up, restarted whenever the oscillator is off
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hi_cnt_r     <= 15'h0000;
			high_ready_o <= 1'b0;
		end else if (!high_osc_en_o) begin
			hi_cnt_r     <= 15'h0000;
			high_ready_o <= 1'b0;
		end else if (HIGH_IS_RC) begin
			high_ready_o <= 1'b1;
		end else if (!high_ready_o && high_osc_tick_i) begin
			hi_cnt_r <= hi_cnt_r + 15'h0001;
			if (hi_cnt_r == ocd_pkg::HI_WARM_LAST) high_ready_o <= 1'b1;
		end
	end

	// Low warm-up counts high pulses; falls back to low pulses if high is off
	assign lo_adv = high_osc_en_o ? high_osc_tick_i : low_osc_tick_i;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lo_cnt_r    <= 9'h000;
			low_ready_o <= 1'b0;
		end else if (!low_osc_en_o) begin
			lo_cnt_r    <= 9'h000;
			low_ready_o <= 1'b0;
		end else if (LOW_IS_RC) begin
			low_ready_o <= 1'b1;
		end else if (!low_ready_o && lo_adv) begin
			lo_cnt_r <= lo_cnt_r + 9'h001;
			if (lo_cnt_r == ocd_pkg::LO_WARM_LAST) low_ready_o <= 1'b1;
		end
	end

	// System clock source follows the applied mode once the target is warm
	assign target_high = eff_r[ocd_pkg::BIT_HIGH_RUN];
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) sys_sel_high_o <= ocd_pkg::MODE_RST[ocd_pkg::BIT_HIGH_RUN];
		else if (target_high && !sys_sel_high_o && high_ready_o) sys_sel_high_o <= 1'b1;
		else if (!target_high && sys_sel_high_o && low_ready_o) sys_sel_high_o <= 1'b0;
	end

	// System clock gated by power state and by warm-up of its source
	assign sys_en   = state_r == ocd_pkg::OCD_RUN &&
	                  (sys_sel_high_o ? high_ready_o : low_ready_o);
	assign sel_tick = sys_sel_high_o ? high_osc_tick_i : low_osc_tick_i;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cpu_run_o      <= 1'b0;
			sys_clk_tick_o <= 1'b0;
		end else begin
			cpu_run_o      <= sys_en;
			sys_clk_tick_o <= sys_en && sel_tick;
		end
	end

	// Vector jump is signalled once the system clock is back after a wake
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wake_pend_r <= 1'b0;
			resume_o    <= 1'b0;
		end else begin
			resume_o <= wake_pend_r && sys_en;
			if (wake_i && state_r != ocd_pkg::OCD_RUN) wake_pend_r <= 1'b1;
			else if (sys_en) wake_pend_r <= 1'b0;
		end
	end

	// Display and quadrupler clocks
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			display_clk_o <= 1'b0;
			quad_clk_o    <= 1'b0;
		end else begin
			display_clk_o <= ctrl_r.disp_gate && low_osc_en_o && low_osc_tick_i;
			quad_clk_o    <= upper_adv;
		end
	end

	// Divider: low stages on high pulses, upper stages on low pulses or stage 6
	assign stage6_carry = high_osc_en_o && high_osc_tick_i &&
	                      div_o[ocd_pkg::DIV_LO_WIDTH-1:0] == 6'h3F;
	assign upper_adv    = low_osc_en_o ? low_osc_tick_i : stage6_carry;
	always_comb begin
		div_nxt = div_o;
		if (high_osc_en_o && high_osc_tick_i)
			div_nxt[5:0] = div_o[5:0] + 6'h01;
		if (upper_adv)
			div_nxt[20:6] = div_o[20:6] + 15'h0001;
		if (clr_wr)
			div_nxt = div_nxt & ocd_keep_mask(rf_wdata_i);
	end
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) div_o <= 21'h000000;
		else div_o <= div_nxt;
	end

	// Checks next to the logic
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	a_mode_osc_drive: assert property (
		(state_r == ocd_pkg::OCD_RUN && $stable(state_r)) |=>
		(low_osc_en_o == $past(eff_r[0]) && high_osc_en_o == $past(eff_r[1])))
		else $error("oscillator enables do not follow applied mode");

	a_alloff_hold: assert property (
		(mode_wr && rf_wdata_i[1:0] == ocd_pkg::ALL_OFF_MODE && state_r == ocd_pkg::OCD_RUN)
		|=> $stable(eff_r))
		else $error("all-off write changed applied mode");

	a_halt_entry: assert property (
		(state_r == ocd_pkg::OCD_RUN && halt_i &&
		 {ctrl_r.high_run, ctrl_r.low_run} == ocd_pkg::LOW_ONLY_MODE && !wake_i)
		|=> state_r == ocd_pkg::OCD_HALT ##1 (low_osc_en_o && !high_osc_en_o && !cpu_run_o))
		else $error("halt entry wrong");

	a_stop_entry: assert property (
		(state_r == ocd_pkg::OCD_RUN && halt_i &&
		 {ctrl_r.high_run, ctrl_r.low_run} == ocd_pkg::ALL_OFF_MODE && !wake_i)
		|=> state_r == ocd_pkg::OCD_STOP ##1 (!low_osc_en_o && !high_osc_en_o && !cpu_run_o))
		else $error("stop entry wrong");

	a_disp_gate: assert property (
		display_clk_o |-> ($past(ctrl_r.disp_gate) && $past(low_osc_en_o) && $past(low_osc_tick_i)))
		else $error("display clock without gate or low oscillator");

	a_disp_stop: assert property (
		!low_osc_en_o |=> !display_clk_o)
		else $error("display clock while low oscillator stopped");

	a_warm_gate: assert property (
		cpu_run_o |-> ($past(sys_sel_high_o) ? $past(high_ready_o) : $past(low_ready_o)))
		else $error("system clock from oscillator still warming");

	a_tick_gate: assert property (
		sys_clk_tick_o |-> cpu_run_o)
		else $error("system clock pulse while system clock disabled");

	a_switch_pend: assert property (
		(state_r == ocd_pkg::OCD_RUN && target_high && !sys_sel_high_o && !high_ready_o &&
		 low_ready_o) |=> (cpu_run_o && !sys_sel_high_o))
		else $error("pending switch did not keep the old system clock");

	a_rc_high_skip: assert property (
		(HIGH_IS_RC && high_osc_en_o) |=> high_ready_o)
		else $error("RC high oscillator was made to warm up");

	a_rc_low_skip: assert property (
		(LOW_IS_RC && low_osc_en_o) |=> low_ready_o)
		else $error("RC low oscillator was made to warm up");

	a_div_low_count: assert property (
		(high_osc_en_o && high_osc_tick_i && !clr_wr) |=>
		div_o[5:0] == $past(div_o[5:0]) + 6'h01)
		else $error("low divider stages did not count a high pulse");

	a_div_from_low: assert property (
		(low_osc_en_o && low_osc_tick_i && !clr_wr) |=>
		div_o[20:6] == $past(div_o[20:6]) + 15'h0001)
		else $error("upper divider stages did not count a low pulse");

	a_div_from_st6: assert property (
		(!low_osc_en_o && !clr_wr && div_o[5:0] != 6'h3F) |=> $stable(div_o[20:6]))
		else $error("upper divider stages moved without a stage 6 carry");

	a_stop_wake: assert property (
		(state_r == ocd_pkg::OCD_STOP && wake_i) |=>
		(state_r == ocd_pkg::OCD_RUN && eff_r == ocd_pkg::BOTH_RUNNING_MODE))
		else $error("wake from stop did not restart both oscillators");

	a_halt_wake: assert property (
		(state_r == ocd_pkg::OCD_HALT && wake_i) |=>
		(state_r == ocd_pkg::OCD_RUN && low_osc_en_o && !high_osc_en_o))
		else $error("wake from halt left low-only mode");

	a_resume_once: assert property (
		resume_o |=> !resume_o)
		else $error("resume pulse longer than one cycle");

	a_high_warm_len: assert property (
		($rose(high_ready_o) && !HIGH_IS_RC) |-> $past(hi_cnt_r) == ocd_pkg::HI_WARM_LAST)
		else $error("high warm-up length wrong");

	a_low_warm_len: assert property (
		($rose(low_ready_o) && !LOW_IS_RC) |-> $past(lo_cnt_r) == ocd_pkg::LO_WARM_LAST)
		else $error("low warm-up length wrong");

	a_switch_wait: assert property (
		$changed(sys_sel_high_o) |-> (sys_sel_high_o ? $past(high_ready_o) : $past(low_ready_o)))
		else $error("system clock switched before warm-up");

	a_div_clear: assert property (
		(clr_wr && rf_wdata_i[0] && rf_wdata_i[3]) |=> (div_o[5:0] == 6'h00 && div_o[20:17] == 4'h0))
		else $error("divider segment not cleared");

	a_warm_restart: assert property (
		!high_osc_en_o |=> (hi_cnt_r == 15'h0000 && !high_ready_o))
		else $error("high warm-up counter not restarted");

	c_enter_stop: cover property (state_r == ocd_pkg::OCD_RUN ##1 state_r == ocd_pkg::OCD_STOP);
	c_enter_halt: cover property (state_r == ocd_pkg::OCD_RUN ##1 state_r == ocd_pkg::OCD_HALT);
	c_resume:     cover property (resume_o);
	c_to_low:     cover property ($fell(sys_sel_high_o));
	c_to_high:    cover property ($rose(sys_sel_high_o));

endmodule : ocd_osc_div

// >>> design/ocd_pkg.sv
// Constants and types shared by the oscillator mode and divider block
package ocd_pkg;

	// Register file coordinates (page / address)
	localparam logic [2:0] PAGE_OSC    = 3'h2;
	localparam logic [2:0] ADDR_MODE   = 3'h6;
	localparam logic [2:0] ADDR_DIVCLR = 3'h7;

	// Bit positions inside the mode register
	localparam int BIT_LOW_RUN   = 0;
	localparam int BIT_HIGH_RUN  = 1;
	localparam int BIT_DISP_GATE = 2;

	// Mode codes as {high_osc_run_bit, low_osc_run_bit}
	localparam logic [1:0] ALL_OFF_MODE      = 2'h0;
	localparam logic [1:0] LOW_ONLY_MODE     = 2'h1;
	localparam logic [1:0] HIGH_ONLY_MODE    = 2'h2;
	localparam logic [1:0] BOTH_RUNNING_MODE = 2'h3;

	// Values after reset
	localparam logic [1:0] MODE_RST      = BOTH_RUNNING_MODE;
	localparam logic       DISP_GATE_RST = 1'b0;

	// Warm-up counters
	localparam int          HI_WARM_STAGES = 15;
	localparam int          HI_WARM_PULSES = 16384;
	localparam int          LO_WARM_STAGES = 9;
	localparam int          LO_WARM_PULSES = 256;
	localparam logic [14:0] HI_WARM_LAST   = 15'(HI_WARM_PULSES - 1);
	localparam logic [8:0]  LO_WARM_LAST   = 9'(LO_WARM_PULSES - 1);

	// Binary divider layout (stage n sits at bit n-1)
	localparam int DIV_STAGES   = 21;
	localparam int DIV_LO_WIDTH = 6;
	localparam int SEG2_LSB     = 6;
	localparam int SEG3_LSB     = 12;
	localparam int SEG4_LSB     = 17;

	// Software-visible control fields
	typedef struct packed {
		logic disp_gate;
		logic high_run;
		logic low_run;
	} ocd_ctrl_t;

	// Power state, Gray coded along run -> halt -> stop
	typedef enum logic [1:0] {
		OCD_RUN  = 2'h0,
		OCD_HALT = 2'h1,
		OCD_STOP = 2'h3
	} ocd_state_t;

endpackage : ocd_pkg

// >>> verif/tb_top.sv
// Self-checking testbench for the oscillator mode and divider block
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_i           = 1'b0;
	logic        rstn_i          = 1'b0;
	logic [2:0]  rf_page_i       = 3'h0;
	logic [2:0]  rf_addr_i       = 3'h0;
	logic [3:0]  rf_wdata_i      = 4'h0;
	logic        rf_we_i         = 1'b0;
	logic        halt_i          = 1'b0;
	logic        wake_i          = 1'b0;
	logic        low_osc_tick_i  = 1'b0;
	logic        high_osc_tick_i = 1'b0;
	logic [3:0]  rf_rdata_o;
	logic        low_osc_en_o;
	logic        high_osc_en_o;
	logic        low_ready_o;
	logic        high_ready_o;
	logic        sys_sel_high_o;
	logic        cpu_run_o;
	logic        sys_clk_tick_o;
	logic        resume_o;
	logic        display_clk_o;
	logic        quad_clk_o;
	logic [20:0] div_o;
	int          mismatches  = 0;
	int          comparisons = 0;
	bit          hi_on       = 1'b1;
	bit          lo_on       = 1'b1;
	logic [3:0]  rv;
	logic [3:0]  msk;
	logic [20:0] snap;
	int          cnt;
	logic        rc_low_ready;
	logic        rc_high_ready;

	ocd_osc_div u_dut (
		.clk_i           (clk_i),
		.rstn_i          (rstn_i),
		.rf_page_i       (rf_page_i),
		.rf_addr_i       (rf_addr_i),
		.rf_wdata_i      (rf_wdata_i),
		.rf_we_i         (rf_we_i),
		.rf_rdata_o      (rf_rdata_o),
		.halt_i          (halt_i),
		.wake_i          (wake_i),
		.low_osc_tick_i  (low_osc_tick_i),
		.high_osc_tick_i (high_osc_tick_i),
		.low_osc_en_o    (low_osc_en_o),
		.high_osc_en_o   (high_osc_en_o),
		.low_ready_o     (low_ready_o),
		.high_ready_o    (high_ready_o),
		.sys_sel_high_o  (sys_sel_high_o),
		.cpu_run_o       (cpu_run_o),
		.sys_clk_tick_o  (sys_clk_tick_o),
		.resume_o        (resume_o),
		.display_clk_o   (display_clk_o),
		.quad_clk_o      (quad_clk_o),
		.div_o           (div_o)
	);

	// Same block with both oscillators set up as RC: no warm-up
	ocd_osc_div #(
		.LOW_IS_RC  (1'b1),
		.HIGH_IS_RC (1'b1)
	) u_dut_rc (
		.clk_i           (clk_i),
		.rstn_i          (rstn_i),
		.rf_page_i       (rf_page_i),
		.rf_addr_i       (rf_addr_i),
		.rf_wdata_i      (rf_wdata_i),
		.rf_we_i         (rf_we_i),
		.rf_rdata_o      (),
		.halt_i          (halt_i),
		.wake_i          (wake_i),
		.low_osc_tick_i  (low_osc_tick_i),
		.high_osc_tick_i (high_osc_tick_i),
		.low_osc_en_o    (),
		.high_osc_en_o   (),
		.low_ready_o     (rc_low_ready),
		.high_ready_o    (rc_high_ready),
		.sys_sel_high_o  (),
		.cpu_run_o       (),
		.sys_clk_tick_o  (),
		.resume_o        (),
		.display_clk_o   (),
		.quad_clk_o      (),
		.div_o           ()
	);

	// Clock generator
	always #5 clk_i = ~clk_i;

	// Oscillator pulses: high every cycle, low at random
	always @(posedge clk_i) begin
		high_osc_tick_i <= hi_on;
		low_osc_tick_i  <= lo_on & 1'($urandom % 2);
	end

	// Divider contents after a segment clear
	function automatic logic [20:0] clr_exp(logic [20:0] d, logic [3:0] m);
		if (m[0]) d[5:0] = 6'h00;
		if (m[1]) d[11:6] = 6'h00;
		if (m[2]) d[16:12] = 5'h00;
		if (m[3]) d[20:17] = 4'h0;
		return d;
	endfunction : clr_exp

	// Wait cycles and settle past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc

	// One register write
	task automatic wr(input logic [2:0] pg, input logic [2:0] ad, input logic [3:0] d);
		@(posedge clk_i);
		rf_page_i  <= pg;
		rf_addr_i  <= ad;
		rf_wdata_i <= d;
		rf_we_i    <= 1'b1;
		@(posedge clk_i);
		rf_we_i <= 1'b0;
		#1;
	endtask : wr

	// One register read
	task automatic rd(input logic [2:0] pg, input logic [2:0] ad, output logic [3:0] d);
		@(posedge clk_i);
		rf_page_i <= pg;
		rf_addr_i <= ad;
		cyc(1);
		d = rf_rdata_o;
	endtask : rd

	// One-cycle pulse on halt or wake
	task automatic pulse(input bit is_wake);
		@(posedge clk_i);
		if (is_wake) wake_i <= 1'b1; else halt_i <= 1'b1;
		@(posedge clk_i);
		wake_i <= 1'b0;
		halt_i <= 1'b0;
		#1;
	endtask : pulse

	// Bounded wait for the resume pulse
	task automatic wait_resume();
		int n;
		n = 0;
		while (resume_o !== 1'b1 && n < 40000) begin
			cyc(1);
			n++;
		end
	endtask : wait_resume

	// Count display clock pulses over a span
	task automatic disp_count(input int n, output int c);
		c = 0;
		repeat (n) begin
			cyc(1);
			if (display_clk_o === 1'b1) c++;
		end
	endtask : disp_count

	// Verdict and end of run
	task automatic finish_test();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// Watchdog
	initial begin
		#800us;
		mismatches++;
		finish_test();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h41456DFA));
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		cyc(16000);
		`CHK(high_ready_o, 1'b0)
		`CHK(sys_clk_tick_o, 1'b0)
		`CHK({rc_low_ready, rc_high_ready}, 2'h3)
		cnt = 0;
		while (high_ready_o !== 1'b1 && cnt < 1000) begin
			cyc(1);
			cnt++;
		end
		`CHK(high_ready_o, 1'b1)
		rd(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_MODE, rv);
		`CHK(rv, 4'h3)
		rd(3'h3, 3'h6, rv);
		`CHK(rv, 4'h0)
		rd(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_DIVCLR, rv);
		`CHK(rv, 4'h0)
		disp_count(40, cnt);
		`CHK(cnt, 0)
		// Random segment clears with oscillator pulses stopped
		repeat (8) begin
			hi_on = 1'b1;
			lo_on = 1'b1;
			cyc(1 + $urandom % 200);
			hi_on = 1'b0;
			lo_on = 1'b0;
			cyc(3);
			snap = div_o;
			msk = 4'($urandom);
			wr(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_DIVCLR, msk);
			cyc(2);
			`CHK(div_o, clr_exp(snap, msk))
		end
		wr(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_DIVCLR, 4'hF);
		cyc(2);
		hi_on = 1'b1;
		cyc(1);
		hi_on = 1'b0;
		cyc(3);
		`CHK(div_o, 21'h000001)
		hi_on = 1'b1;
		lo_on = 1'b1;
		// Gate on passes the low clock
		wr(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_MODE, 4'h7);
		rd(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_MODE, rv);
		`CHK(rv, 4'h7)
		disp_count(40, cnt);
		`CHK(cnt > 0, 1'b1)
		// All-off write waits for the halt
		wr(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_MODE, 4'h4);
		cyc(5);
		`CHK({low_osc_en_o, high_osc_en_o, sys_sel_high_o}, 3'h7)
		pulse(1'b0);
		cyc(3);
		`CHK({low_osc_en_o, high_osc_en_o, cpu_run_o}, 3'h0)
		disp_count(40, cnt);
		`CHK(cnt, 0)
		pulse(1'b1);
		wait_resume();
		`CHK(resume_o, 1'b1)
		`CHK({high_osc_en_o, high_ready_o, sys_sel_high_o}, 3'h7)
		rd(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_MODE, rv);
		`CHK(rv[1:0], ocd_pkg::BOTH_RUNNING_MODE)
		// Low-only mode, then halt and wake
		wr(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_MODE, 4'h5);
		cyc(4);
		`CHK({high_osc_en_o, sys_sel_high_o, low_osc_en_o}, 3'h1)
		pulse(1'b0);
		cyc(3);
		`CHK({low_osc_en_o, high_osc_en_o, cpu_run_o}, 3'h4)
		disp_count(40, cnt);
		`CHK(cnt > 0, 1'b1)
		pulse(1'b1);
		wait_resume();
		`CHK(resume_o, 1'b1)
		rd(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_MODE, rv);
		`CHK(rv[1:0], ocd_pkg::LOW_ONLY_MODE)
		`CHK(sys_sel_high_o, 1'b0)
		// Back to both running: CPU stays on the low clock while high warms up
		wr(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_MODE, 4'h3);
		cyc(3);
		`CHK({sys_sel_high_o, cpu_run_o, high_ready_o}, 3'h2)
		cnt = 3;
		while (high_ready_o !== 1'b1 && cnt < 17000) begin
			cyc(1);
			cnt++;
		end
		`CHK(cnt, ocd_pkg::HI_WARM_PULSES + 1)
		cyc(1);
		`CHK(sys_sel_high_o, 1'b1)
		cyc(1);
		`CHK(sys_clk_tick_o, 1'b1)
		// High only with the gate set: low stops, upper stages take stage 6
		wr(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_MODE, 4'h6);
		cyc(3);
		`CHK({low_osc_en_o, low_ready_o, high_osc_en_o, sys_sel_high_o}, 4'h3)
		hi_on = 1'b0;
		cyc(3);
		wr(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_DIVCLR, 4'hF);
		hi_on = 1'b1;
		cyc(64);
		hi_on = 1'b0;
		cyc(1);
		`CHK(quad_clk_o, 1'b1)
		cyc(3);
		`CHK(div_o, 21'h000040)
		disp_count(40, cnt);
		`CHK(cnt, 0)
		// Both again: low warm-up length counted in high pulses
		hi_on = 1'b1;
		wr(ocd_pkg::PAGE_OSC, ocd_pkg::ADDR_MODE, 4'h3);
		cnt = 0;
		while (low_ready_o !== 1'b1 && cnt < 1000) begin
			cyc(1);
			cnt++;
		end
		`CHK(cnt, ocd_pkg::LO_WARM_PULSES + 1)
		cyc(100);
		finish_test();
	end

endmodule : tb_top
